/* File: verilog/pcrcg_top.sv */
// Programmable checksum generator: register port, input FIFO and bit-serial shift engine.
// Assumes a synchronous register master that never waits and power-mode levels
// synchronous to clk.
`timescale 1ns/100ps

module pcrcg_top (
  input  wire logic                          clk,        // 100 MHz clock
  input  wire logic                          rst_b,      // Synchronous reset, low
  input  wire logic [pcrcg_pkg::ADDR_W-1:0]  addr,       // Register word address
  input  wire logic [pcrcg_pkg::DATA_W-1:0]  wdata,      // Write data
  input  wire logic                          wr_en,      // Write strobe
  input  wire logic                          rd_en,      // Read strobe
  input  wire logic                          sleep_mode, // Device in sleep
  input  wire logic                          idle_mode,  // Device in idle
  output logic      [pcrcg_pkg::DATA_W-1:0]  rdata,      // Read data, cycle after strobe
  output logic                               crc_irq     // Drain interrupt pulse
);
  import pcrcg_pkg::*;

  pcrcg_regs_t s_r;
  pcrcg_regs_t s_nxt;

  // Mask keeping only the bits of a register whose length is len+1
  function automatic logic [DATA_W-1:0] len_mask(input logic [LEN_W-1:0] len);
    len_mask = ALL_ONES >> (TOP_LEN - len);
  endfunction : len_mask

  function automatic logic [PTR_W-1:0] ptr_inc(input logic [PTR_W-1:0] p,
                                               input logic [CNT_W-1:0] depth);
    logic [CNT_W-1:0] q;
    q = {1'b0, p} + {1'b0, PTR_ONE};
    ptr_inc = (q == depth) ? PTR_ZERO : q[PTR_W-1:0];
  endfunction : ptr_inc

  logic [CNT_W-1:0]  depth;
  logic              full;
  logic              empty;
  logic [DATA_W-1:0] mask;
  logic [DATA_W-1:0] poly;
  logic              frozen;

  always_comb begin
    depth  = (s_r.len > LEN_DEEP_MAX) ? DEPTH_SHORT : DEPTH_LONG;
    full   = (s_r.count == depth);
    empty  = (s_r.count == CNT_ZERO);
    mask   = len_mask(s_r.len);
    poly   = {s_r.taps[DATA_W-1:1], 1'b1} & mask;
    frozen = sleep_mode | (idle_mode & s_r.idle_stop);
  end

  logic              push;
  logic              pop;
  logic              roll;
  logic              fb;
  logic [DATA_W-1:0] shifted;

  always_comb begin
    s_nxt   = s_r;
    s_nxt.irq = 1'b0;
    s_nxt.rdata = ZERO_WORD;
    push    = 1'b0;
    pop     = 1'b0;
    roll    = 1'b0;
    fb      = 1'b0;
    shifted = ZERO_WORD;

    // Register reads
    if (rd_en) begin
      unique case (addr)
        ADDR_CTRL: begin
          s_nxt.rdata[CTRL_LEN_LSB +: LEN_W] = s_r.len;
          s_nxt.rdata[CTRL_RUN_BIT]          = s_r.run;
          s_nxt.rdata[CTRL_EMPTY_BIT]        = empty;
          s_nxt.rdata[CTRL_FULL_BIT]         = full;
          s_nxt.rdata[CTRL_CNT_LSB +: CNT_W] = s_r.count;
          s_nxt.rdata[CTRL_IDLE_BIT]         = s_r.idle_stop;
        end
        ADDR_TAPS:  s_nxt.rdata = {s_r.taps[DATA_W-1:1], 1'b0};
        ADDR_DATA:  s_nxt.rdata = s_r.crc;
        ADDR_INPUT: s_nxt.rdata = ZERO_WORD;
      endcase
    end

    // Register writes
    if (wr_en) begin
      unique case (addr)
        ADDR_CTRL: begin
          s_nxt.len       = wdata[CTRL_LEN_LSB +: LEN_W];
          s_nxt.run       = wdata[CTRL_RUN_BIT];
          s_nxt.idle_stop = wdata[CTRL_IDLE_BIT];
        end
        ADDR_TAPS:  s_nxt.taps = {wdata[DATA_W-1:1], 1'b0};
        ADDR_DATA:  s_nxt.crc  = wdata & mask;
        ADDR_INPUT: begin
          if (full) begin
            roll = 1'b1;
          end else begin
            push = 1'b1;
            s_nxt.mem[s_r.wptr] = wdata & mask;
          end
        end
      endcase
    end

    // Serial shift engine, halted while frozen or while run is low
    if (!frozen) begin
      unique case (s_r.st)
        PCRCG_ST_IDLE: begin
          if (s_r.run && !empty) begin
            s_nxt.st      = PCRCG_ST_SHIFT;
            s_nxt.bit_idx = s_r.len;
          end
        end
        PCRCG_ST_SHIFT: begin
          if (s_r.run) begin
            fb      = s_r.mem[s_r.rptr][s_r.bit_idx] ^ s_r.crc[s_r.len];
            shifted = (s_r.crc << 1) & mask;
            s_nxt.crc = fb ? (shifted ^ poly) : shifted;
            if (s_r.bit_idx == LEN_RST) begin
              pop = 1'b1;
              s_nxt.bit_idx = s_r.len;
              if (s_r.count == CNT_ONE && !push) begin
                s_nxt.st = PCRCG_ST_IDLE;
              end
            end else begin
              s_nxt.bit_idx = s_r.bit_idx - 4'h1;
            end
          end
        end
      endcase
    end

    // FIFO bookkeeping; rollover overrides a same-cycle pop
    if (roll) begin
      s_nxt.count   = CNT_ZERO;
      s_nxt.wptr    = PTR_ZERO;
      s_nxt.rptr    = PTR_ZERO;
      s_nxt.st      = PCRCG_ST_IDLE;
      s_nxt.bit_idx = s_r.len;
    end else begin
      if (push) begin
        s_nxt.wptr = ptr_inc(s_r.wptr, depth);
      end
      if (pop) begin
        s_nxt.rptr = ptr_inc(s_r.rptr, depth);
      end
      if (push && !pop) begin
        s_nxt.count = s_r.count + CNT_ONE;
      end else if (pop && !push) begin
        s_nxt.count = s_r.count - CNT_ONE;
        s_nxt.irq   = (s_r.count == CNT_ONE);
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      s_r.mem       <= '0;
      s_r.crc       <= CRC_RST;
      s_r.taps      <= TAPS_RST;
      s_r.rdata     <= ZERO_WORD;
      s_r.len       <= LEN_RST;
      s_r.bit_idx   <= LEN_RST;
      s_r.wptr      <= PTR_ZERO;
      s_r.rptr      <= PTR_ZERO;
      s_r.count     <= CNT_ZERO;
      s_r.st        <= PCRCG_ST_IDLE;
      s_r.run       <= 1'b0;
      s_r.idle_stop <= 1'b0;
      s_r.irq       <= 1'b0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign rdata   = s_r.rdata;
  assign crc_irq = s_r.irq;

endmodule : pcrcg_top

/* File: verilog/pcrcg_pkg.sv */
// Constants, register map and state codes for the programmable checksum generator.
// Assumes a 16-bit register port with word addresses and a single 100 MHz clock.
package pcrcg_pkg;

  localparam int unsigned DATA_W       = 16;
  localparam int unsigned ADDR_W       = 2;
  localparam int unsigned PTR_W        = 4;
  localparam int unsigned CNT_W        = 5;
  localparam int unsigned LEN_W        = 4;
  localparam int unsigned FIFO_SLOTS   = 16;

  // Register word addresses
  localparam logic [ADDR_W-1:0] ADDR_CTRL  = 2'h0;
  localparam logic [ADDR_W-1:0] ADDR_TAPS  = 2'h1;
  localparam logic [ADDR_W-1:0] ADDR_DATA  = 2'h2;
  localparam logic [ADDR_W-1:0] ADDR_INPUT = 2'h3;

  // Control register fields
  localparam int unsigned CTRL_LEN_LSB   = 0;
  localparam int unsigned CTRL_RUN_BIT   = 4;
  localparam int unsigned CTRL_EMPTY_BIT = 6;
  localparam int unsigned CTRL_FULL_BIT  = 7;
  localparam int unsigned CTRL_CNT_LSB   = 8;
  localparam int unsigned CTRL_IDLE_BIT  = 13;

  // Depth selection
  localparam logic [LEN_W-1:0] LEN_DEEP_MAX = 4'h7;
  localparam logic [CNT_W-1:0] DEPTH_SHORT  = 5'h08;
  localparam logic [CNT_W-1:0] DEPTH_LONG   = 5'h10;

  // Reset values and fixed constants
  localparam logic [LEN_W-1:0]  LEN_RST   = 4'h0;
  localparam logic [DATA_W-1:0] TAPS_RST  = 16'h0000;
  localparam logic [DATA_W-1:0] CRC_RST   = 16'h0000;
  localparam logic [DATA_W-1:0] ALL_ONES  = 16'hffff;
  localparam logic [DATA_W-1:0] ZERO_WORD = 16'h0000;
  localparam logic [PTR_W-1:0]  PTR_ZERO  = 4'h0;
  localparam logic [PTR_W-1:0]  PTR_ONE   = 4'h1;
  localparam logic [CNT_W-1:0]  CNT_ZERO  = 5'h00;
  localparam logic [CNT_W-1:0]  CNT_ONE   = 5'h01;
  localparam logic [LEN_W-1:0]  TOP_LEN   = 4'hf;

  typedef enum logic [1:0] {
    PCRCG_ST_IDLE  = 2'b01,
    PCRCG_ST_SHIFT = 2'b10
  } pcrcg_state_t;

  typedef struct packed {
    logic [FIFO_SLOTS-1:0][DATA_W-1:0] mem;
    logic [DATA_W-1:0]                 crc;
    logic [DATA_W-1:0]                 taps;
    logic [DATA_W-1:0]                 rdata;
    logic [LEN_W-1:0]                  len;
    logic [LEN_W-1:0]                  bit_idx;
    logic [PTR_W-1:0]                  wptr;
    logic [PTR_W-1:0]                  rptr;
    logic [CNT_W-1:0]                  count;
    pcrcg_state_t                      st;
    logic                              run;
    logic                              idle_stop;
    logic                              irq;
  } pcrcg_regs_t;

endpackage : pcrcg_pkg

/* File: test/pcrcg_checker.sv */
// Assertions on the checksum generator register port and interrupt.
// Bound into pcrcg_top; sees only its ports.
`timescale 1ns/100ps
module pcrcg_checker (
  input wire logic                         clk,        // Clock
  input wire logic                         rst_b,      // Reset, low
  input wire logic [pcrcg_pkg::ADDR_W-1:0] addr,       // Address
  input wire logic [pcrcg_pkg::DATA_W-1:0] wdata,      // Write data
  input wire logic                         wr_en,      // Write strobe
  input wire logic                         rd_en,      // Read strobe
  input wire logic                         sleep_mode, // Sleep
  input wire logic                         idle_mode,  // Idle
  input wire logic [pcrcg_pkg::DATA_W-1:0] rdata,      // Read data
  input wire logic                         crc_irq     // Interrupt
);
  import pcrcg_pkg::*;
  wire rd_ctl = rd_en && addr == ADDR_CTRL;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);
  AST_RD_IDLE: assert property (!rd_en |=> rdata == ZERO_WORD) else $error("stray rdata");
  AST_IN_PORT: assert property (rd_en && addr == ADDR_INPUT |=> rdata == ZERO_WORD)
    else $error("input port read not zero");
  AST_CTRL_RB:
    assert property ((wr_en && addr == ADDR_CTRL ##1 !wr_en ##1 rd_ctl) |=>
      (rdata & 16'h201f) == ($past(wdata, 3) & 16'h201f)) else $error("ctrl readback");
  AST_TAPS_RB:
    assert property ((wr_en && addr == ADDR_TAPS ##1 !wr_en ##1 rd_en && addr == ADDR_TAPS)
      |=> rdata == ($past(wdata, 3) & 16'hfffe)) else $error("taps readback");
  AST_EMPTY: assert property (rd_ctl |=> rdata[6] == (rdata[12:8] == CNT_ZERO))
    else $error("empty flag");
  AST_FULL:
    assert property (rd_ctl |=> rdata[7] == (rdata[12:8] ==
      (rdata[3:0] > LEN_DEEP_MAX ? DEPTH_SHORT : DEPTH_LONG))) else $error("full flag");
  AST_RSVD: assert property (rd_ctl |=> rdata[15:14] == 2'h0 && !rdata[5])
    else $error("reserved ctrl bits");
  AST_IRQ_PULSE: assert property (crc_irq |=> !crc_irq) else $error("irq too long");
  AST_SLEEP: assert property (sleep_mode [*2] |=> !crc_irq) else $error("irq in sleep");
  cover property (crc_irq);
  cover property (rd_ctl ##1 rdata[7]);
  cover property (idle_mode ##1 !idle_mode);
endmodule : pcrcg_checker

bind pcrcg_top pcrcg_checker u_chk (.clk(clk), .rst_b(rst_b), .addr(addr), .wdata(wdata),
  .wr_en(wr_en), .rd_en(rd_en), .sleep_mode(sleep_mode), .idle_mode(idle_mode),
  .rdata(rdata), .crc_irq(crc_irq));

/* File: test/test_pcrcg_top.sv */
// Testbench for the checksum generator: register tasks, drain, rollover, freeze.
// Drives pcrcg_top directly at 100 MHz with a synchronous active-low reset.
`timescale 1ns/100ps
module test_pcrcg_top;
  import pcrcg_pkg::*;
  logic              clk = 0, rst_b = 0, wr_en = 0, rd_en = 0;
  logic              sleep_mode = 0, idle_mode = 0, crc_irq;
  logic [ADDR_W-1:0] addr = '0;
  logic [DATA_W-1:0] wdata = '0, rdata, c;
  int                fails = 0, num_checks = 0, irqs = 0, n;
  always #5 clk = ~clk;
  always @(posedge clk) if (crc_irq === 1'b1) irqs <= irqs + 1;
  pcrcg_top DUT (.clk(clk), .rst_b(rst_b), .addr(addr), .wdata(wdata), .wr_en(wr_en),
    .rd_en(rd_en), .sleep_mode(sleep_mode), .idle_mode(idle_mode), .rdata(rdata),
    .crc_irq(crc_irq));
  task automatic end_of_test;
    if (fails == 0 && num_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : end_of_test
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [1:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask : wr
  task automatic rd(input logic [1:0] a, input logic [15:0] e);
    @(posedge clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    #1 chk(rdata, e);
  endtask : rd
  // Counts edges until the drain pulse is seen
  task automatic wait_irq;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (crc_irq !== 1'b1 && n < 300);
  endtask : wait_irq
  // Reference remainder, word fed MSB first
  function automatic logic [15:0] crc(input logic [15:0] s, d, t, input logic [3:0] l);
    logic [15:0] m;
    m = 16'((17'h1 << (int'(l) + 1)) - 1);
    for (int i = int'(l); i >= 0; i--)
      s = ((s << 1) & m) ^ ((d[i] ^ s[l]) ? ({t[15:1], 1'b1} & m) : 16'h0000);
    return s;
  endfunction : crc
  initial begin
    #20000;
    fails++;
    end_of_test();
  end
  initial begin
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    rd(ADDR_CTRL, 16'h0040);
    rd(ADDR_TAPS, 16'h0000);
    rd(ADDR_INPUT, 16'h0000);
    wr(ADDR_CTRL, 16'h0007);
    wr(ADDR_TAPS, 16'h0007);
    rd(ADDR_TAPS, 16'h0006);
    wr(ADDR_INPUT, 16'h01a5);
    rd(ADDR_CTRL, 16'h0107);
    @(posedge clk) idle_mode <= 1'b1;
    wr(ADDR_CTRL, 16'h0017);
    wait_irq();
    // One start cycle, eight shift cycles, one cycle to register the pulse
    chk(16'(n), 16'h000a);
    idle_mode <= 1'b0;
    rd(ADDR_CTRL, 16'h0057);
    rd(ADDR_DATA, crc(16'h0000, 16'h00a5, 16'h0006, 4'h7));
    for (int j = 0; j < 2; j++) begin
      c = j ? 16'h000f : 16'h0007;
      wr(ADDR_CTRL, c);
      for (int i = 0; i < (j ? 8 : 16); i++) wr(ADDR_INPUT, 16'(i));
      rd(ADDR_CTRL, c | (j ? 16'h0880 : 16'h1080));
      wr(ADDR_INPUT, 16'h00ff);
      rd(ADDR_CTRL, c | 16'h0040);
    end
    wr(ADDR_CTRL, 16'h001f);
    repeat (40) @(posedge clk);
    chk(16'(irqs), 16'h0001);
    rd(ADDR_DATA, crc(16'h0000, 16'h00a5, 16'h0006, 4'h7));
    wr(ADDR_TAPS, 16'h1020);
    wr(ADDR_DATA, 16'hffff);
    wr(ADDR_CTRL, 16'h200f);
    rd(ADDR_CTRL, 16'h204f);
    wr(ADDR_INPUT, 16'h3132);
    wr(ADDR_INPUT, 16'h3334);
    wr(ADDR_CTRL, 16'h201f);
    repeat (9) @(posedge clk);
    sleep_mode <= 1'b1;
    repeat (40) @(posedge clk);
    rd(ADDR_CTRL, 16'h221f);
    @(posedge clk);
    sleep_mode <= 1'b0;
    idle_mode <= 1'b1;
    repeat (40) @(posedge clk);
    rd(ADDR_CTRL, 16'h221f);
    @(posedge clk) idle_mode <= 1'b0;
    wait_irq();
    rd(ADDR_CTRL, 16'h205f);
    c = crc(crc(16'hffff, 16'h3132, 16'h1020, 4'hf), 16'h3334, 16'h1020, 4'hf);
    rd(ADDR_DATA, c);
    chk(16'(irqs), 16'h0002);
    // Second reset in mid-run must bring the control and taps registers back to their reset values
    @(posedge clk) rst_b <= 1'b0;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    rd(ADDR_CTRL, 16'h0040);
    rd(ADDR_TAPS, 16'h0000);
    end_of_test();
  end
endmodule : test_pcrcg_top
